// File: pkg/aptd_map.svh
`ifndef APTD_MAP_SVH
`define APTD_MAP_SVH
// register offsets on the processor port
`define APTD_OFS_NOLOAD_CFG  8'h0E
`define APTD_OFS_ACC_CFG     8'h0F
`define APTD_OFS_IRQ_EN      8'hD9
`define APTD_OFS_IRQ_ST      8'hDC
`define APTD_OFS_VRMS_OFFSET_TRIM_LO   8'h10
`define APTD_OFS_VRMS_OFFSET_TRIM_HI   8'h11
`define APTD_OFS_GAIN_LO     8'h12
`define APTD_OFS_GAIN_HI     8'h13
`define APTD_OFS_WOS_LO      8'h14
`define APTD_OFS_WOS_HI      8'h15
`define APTD_OFS_MISC_CFG    8'h16
// field positions
`define APTD_ST_SIGN_BIT     0
`define APTD_ST_NOLOAD_BIT   1
`define APTD_ACC_SIGNSEL_BIT 6
`define APTD_MISC_ZXONLY_BIT 0
// reset value of every register byte
`define APTD_RST_BYTE        8'h00
// scaling and timing
`define APTD_VRMS_DIV        5
`define APTD_VRMS_OS_SHIFT   6
`define APTD_GAIN_FRAC       12
`define APTD_WOS_FRAC        8
`define APTD_LPF_SHIFT       8
// no-load thresholds in parts per million of multiplier full scale
`define APTD_NL_PPM1         150
`define APTD_NL_PPM2         75
`define APTD_NL_PPM3         37
`define APTD_PPM_DEN         1000000
`endif

// File: pkg/aptd_pkg.sv
package aptd_pkg;
  // width of one channel sample
  localparam int SMP_W = 16;
  // one current/voltage sample pair
  typedef struct packed {
    logic signed [SMP_W-1:0] cur;
    logic signed [SMP_W-1:0] volt;
  } aptd_sample_s;
  // power results handed downstream
  typedef struct packed {
    logic signed [2*SMP_W-1:0] active;
    logic signed [2*SMP_W-1:0] accum;
  } aptd_power_s;
endpackage

// File: rtl/aptd_core.sv
`include "aptd_map.svh"
`timescale 1ns/100ps
`default_nettype none

module aptd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and control
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             ce,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  // handshakes and index arithmetic
  always_comb begin
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    out_valid = (cnt_reg != '0);
    out_data  = mem_reg[rd_reg];
    wr_next   = push ? AW'((wr_reg + 1'b1) % DEPTH) : wr_reg;
    rd_next   = pop ? AW'((rd_reg + 1'b1) % DEPTH) : rd_reg;
    cnt_next  = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  // storage and indexes
  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else if (ce) begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
      if (push) begin
        mem_reg[wr_reg] <= in_data;
      end
    end
  end
endmodule

module aptd_core #(
  parameter int FIFO_DEPTH = 8
) (
  // clock, reset, enable
  input  wire logic                 mclk,
  input  wire logic                 reset,
  input  wire logic                 ce,
  // processor register port
  input  wire logic [7:0]           sfr_addr,
  input  wire logic                 sfr_wr,
  input  wire logic                 sfr_rd,
  input  wire logic [7:0]           sfr_wdata,
  output logic      [7:0]           sfr_rdata,
  // sample stream
  input  wire logic                 smp_valid,
  output logic                      smp_ready,
  input  wire aptd_pkg::aptd_sample_s smp,
  // voltage rms
  input  wire logic [23:0]          vrms_raw,
  input  wire logic                 zx_pulse,
  output logic      [23:0]          vrms_out,
  output logic                      vrms_upd,
  // power results and interrupt
  output aptd_pkg::aptd_power_s     power,
  output logic                      power_valid,
  output logic                      irq
);
  localparam int PW = 2 * aptd_pkg::SMP_W;
  localparam int SH = `APTD_LPF_SHIFT;
  localparam int AW = PW + SH;
  localparam longint FS = longint'(1) << (PW - 2);

  // threshold from field code
  // zero means detection off
  function automatic logic [PW-1:0] nl_thr(input logic [1:0] code);
    longint t;
    t = 0;
    case (code)
      2'b01:   t = FS * `APTD_NL_PPM1 / `APTD_PPM_DEN;
      2'b10:   t = FS * `APTD_NL_PPM2 / `APTD_PPM_DEN;
      2'b11:   t = FS * `APTD_NL_PPM3 / `APTD_PPM_DEN;
      default: t = 0;
    endcase
    return PW'(t);
  endfunction

  function automatic logic [PW-1:0] mag(input logic signed [PW-1:0] x);
    return x[PW-1] ? PW'(-x) : PW'(x);
  endfunction

  logic [7:0] nl_cfg_reg, nl_cfg_next, acc_cfg_reg, acc_cfg_next;
  logic [7:0] en_reg, en_next, st_reg, st_next, misc_reg, misc_next;
  logic [7:0] rdata_next;
  logic signed [11:0] vos_reg, vos_next, gain_reg, gain_next;
  logic signed [15:0] wos_reg, wos_next;
  logic [2:0]  div_reg, div_next;
  logic [23:0] vrms_next;
  logic        vupd_next, tick, f_valid;
  aptd_pkg::aptd_sample_s f_data;
  logic signed [PW-1:0] prod_reg, prod_next, gp_reg, gp_next;
  logic signed [PW-1:0] pwr_reg, pwr_next, accp_next;
  logic signed [AW-1:0] lpf_reg, lpf_next;
  logic        pv_reg, pv_next, lv_reg, lv_next, gv_reg, gv_next;
  logic        pvalid_next, creep_reg, creep_next, cr2_reg, cr2_next;
  logic        cr3_reg, cr3_next, neg_reg, neg_next;
  logic        sign_evt, nl_evt, below_pwr;
  logic [PW-1:0] thr;
  logic signed [PW+11:0] gprod;
  logic signed [PW+SH-1:0] fx;

  // buffer between the sample stream and the datapath
  aptd_fifo #(.WIDTH($bits(aptd_pkg::aptd_sample_s)), .DEPTH(FIFO_DEPTH))
    u_fifo (
    .mclk      (mclk),
    .reset     (reset),
    .ce        (ce),
    .in_valid  (smp_valid),
    .in_ready  (smp_ready),
    .in_data   (smp),
    .out_valid (f_valid),
    .out_ready (tick),
    .out_data  (f_data)
  );

  // datapath next state, one sample per five cycles
  always_comb begin
    tick      = (div_reg == 3'(`APTD_VRMS_DIV - 1));
    div_next  = tick ? 3'h0 : 3'(div_reg + 3'h1);
    thr       = nl_thr(nl_cfg_reg[1:0]);
    pv_next   = tick && f_valid;
    prod_next = pv_next ? PW'(PW'(f_data.cur) * PW'(f_data.volt))
                        : prod_reg;
    creep_next = pv_next
                 ? (mag(PW'(PW'(f_data.cur) * PW'(f_data.volt))) < thr)
                 : creep_reg;
    lv_next   = pv_reg;
    lpf_next  = pv_reg ? AW'(lpf_reg + AW'(prod_reg) - (lpf_reg >>> SH))
                       : lpf_reg;
    cr2_next  = pv_reg ? creep_reg : cr2_reg;
    // gain trim as fraction of 4096, bounded by 12-bit range
    gv_next   = lv_reg;
    gprod     = (PW+12)'(PW'(lpf_reg >>> SH)) * gain_reg;
    gp_next   = lv_reg ? PW'(PW'(lpf_reg >>> SH)
                + PW'(gprod >>> `APTD_GAIN_FRAC)) : gp_reg;
    cr3_next  = lv_reg ? cr2_reg : cr3_reg;
    // offset trim with eight fractional bits
    fx        = (PW+SH)'(signed'({gp_reg, 8'h00})) + (PW+SH)'(wos_reg);
    pvalid_next = gv_reg;
    pwr_next  = gv_reg ? PW'(fx >>> `APTD_WOS_FRAC) : pwr_reg;
    accp_next = gv_reg ? (cr3_reg ? '0 : PW'(fx >>> `APTD_WOS_FRAC))
                       : power.accum;
    neg_next  = power_valid ? pwr_reg[PW-1] : neg_reg;
    sign_evt  = power_valid && (acc_cfg_reg[`APTD_ACC_SIGNSEL_BIT]
                ? (neg_reg && !pwr_reg[PW-1])
                : (!neg_reg && pwr_reg[PW-1]));
    // no-load level while power under threshold
    below_pwr = mag(pwr_reg) < thr;
    nl_evt    = power_valid && below_pwr;
    // refresh every fifth cycle or at zero crossing
    vupd_next = misc_reg[`APTD_MISC_ZXONLY_BIT] ? zx_pulse : tick;
    // raw plus 64 times the offset trim
    vrms_next = vupd_next ? 24'(vrms_raw
                + {{6{vos_reg[11]}}, vos_reg, 6'h00}) : vrms_out;
  end

  // datapath registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      div_reg <= '0;  pv_reg <= 1'b0;  lv_reg <= 1'b0;  gv_reg <= 1'b0;
      prod_reg <= '0; lpf_reg <= '0;   gp_reg <= '0;    pwr_reg <= '0;
      creep_reg <= 1'b0; cr2_reg <= 1'b0; cr3_reg <= 1'b0;
      neg_reg <= 1'b0; power_valid <= 1'b0; power <= '0;
      vrms_out <= '0; vrms_upd <= 1'b0;
    end else if (ce) begin
      div_reg <= div_next; pv_reg <= pv_next; lv_reg <= lv_next;
      gv_reg <= gv_next;   prod_reg <= prod_next; lpf_reg <= lpf_next;
      gp_reg <= gp_next;   pwr_reg <= pwr_next;
      creep_reg <= creep_next; cr2_reg <= cr2_next; cr3_reg <= cr3_next;
      neg_reg <= neg_next; power_valid <= pvalid_next;
      power.active <= pwr_next;
      power.accum <= accp_next;
      vrms_out <= vrms_next;
      vrms_upd <= vupd_next;
    end
  end

  // register writes, status set wins over clear
  always_comb begin
    nl_cfg_next = nl_cfg_reg;   acc_cfg_next = acc_cfg_reg;
    en_next = en_reg;           misc_next = misc_reg;
    vos_next = vos_reg;         gain_next = gain_reg;
    wos_next = wos_reg;         st_next = st_reg;
    if (sfr_wr) begin
      case (sfr_addr)
        `APTD_OFS_NOLOAD_CFG: nl_cfg_next = sfr_wdata;
        `APTD_OFS_ACC_CFG:    acc_cfg_next = sfr_wdata;
        `APTD_OFS_IRQ_EN:     en_next = sfr_wdata;
        `APTD_OFS_IRQ_ST:     st_next = st_reg & sfr_wdata;
        `APTD_OFS_MISC_CFG:   misc_next = sfr_wdata;
        `APTD_OFS_VRMS_OFFSET_TRIM_LO:  vos_next[7:0] = sfr_wdata;
        `APTD_OFS_VRMS_OFFSET_TRIM_HI:  vos_next[11:8] = sfr_wdata[3:0];
        `APTD_OFS_GAIN_LO:    gain_next[7:0] = sfr_wdata;
        `APTD_OFS_GAIN_HI:    gain_next[11:8] = sfr_wdata[3:0];
        `APTD_OFS_WOS_LO:     wos_next[7:0] = sfr_wdata;
        `APTD_OFS_WOS_HI:     wos_next[15:8] = sfr_wdata;
        default:              st_next = st_reg;
      endcase
    end
    // flags stay until software clears them
    st_next[`APTD_ST_SIGN_BIT]   = st_next[`APTD_ST_SIGN_BIT] | sign_evt;
    st_next[`APTD_ST_NOLOAD_BIT] = st_next[`APTD_ST_NOLOAD_BIT] | nl_evt;
    case (sfr_addr)
      `APTD_OFS_NOLOAD_CFG: rdata_next = nl_cfg_reg;
      `APTD_OFS_ACC_CFG:    rdata_next = acc_cfg_reg;
      `APTD_OFS_IRQ_EN:     rdata_next = en_reg;
      `APTD_OFS_IRQ_ST:     rdata_next = st_reg;
      `APTD_OFS_MISC_CFG:   rdata_next = misc_reg;
      `APTD_OFS_VRMS_OFFSET_TRIM_LO:  rdata_next = vos_reg[7:0];
      `APTD_OFS_VRMS_OFFSET_TRIM_HI:  rdata_next = {4'h0, vos_reg[11:8]};
      `APTD_OFS_GAIN_LO:    rdata_next = gain_reg[7:0];
      `APTD_OFS_GAIN_HI:    rdata_next = {4'h0, gain_reg[11:8]};
      `APTD_OFS_WOS_LO:     rdata_next = wos_reg[7:0];
      `APTD_OFS_WOS_HI:     rdata_next = wos_reg[15:8];
      default:              rdata_next = 8'h00;
    endcase
    if (!sfr_rd) begin
      rdata_next = sfr_rdata;
    end
  end

  // register file
  always_ff @(posedge mclk) begin
    if (reset) begin
      nl_cfg_reg <= `APTD_RST_BYTE; acc_cfg_reg <= `APTD_RST_BYTE;
      en_reg <= `APTD_RST_BYTE;     st_reg <= `APTD_RST_BYTE;
      misc_reg <= `APTD_RST_BYTE;   sfr_rdata <= `APTD_RST_BYTE;
      vos_reg <= '0; gain_reg <= '0; wos_reg <= '0;
    end else if (ce) begin
      nl_cfg_reg <= nl_cfg_next; acc_cfg_reg <= acc_cfg_next;
      en_reg <= en_next;         st_reg <= st_next;
      misc_reg <= misc_next;     sfr_rdata <= rdata_next;
      vos_reg <= vos_next; gain_reg <= gain_next; wos_reg <= wos_next;
    end
  end

  assign irq = |(st_reg & en_reg);

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  chk_vrms_offset: assert property (ce && vupd_next |=>
    vrms_out == 24'($past(vrms_raw) + 64 * 24'(signed'($past(vos_reg)))))
    else $error("vrms correction wrong");
  chk_vrms_rate: assert property (ce && !misc_reg[0]
    && div_reg == 3'h4 |=> vrms_upd)
    else $error("vrms not refreshed at mclk/5");
  chk_sign_neg: assert property (ce && power_valid && !acc_cfg_reg[6]
    && !neg_reg && pwr_reg[PW-1] |=> st_reg[0])
    else $error("positive to negative not flagged");
  chk_sign_pos: assert property (ce && power_valid && acc_cfg_reg[6]
    && neg_reg && !pwr_reg[PW-1] |=> st_reg[0])
    else $error("negative to positive not flagged");
  chk_flag_hold: assert property (st_reg[0] && en_reg[0]
    && !(sfr_wr && sfr_addr == 8'hDC) |=> irq)
    else $error("sign interrupt dropped early");
  chk_creep_block: assert property (ce && gv_reg && cr3_reg
    |=> power.accum == '0) else $error("creep power accumulated");
  chk_noload_flag: assert property (ce && power_valid && below_pwr
    |=> st_reg[1]) else $error("no-load flag not set");
  chk_noload_off: assert property (nl_cfg_reg[1:0] == 2'b00
    |-> !below_pwr) else $error("no-load active while disabled");
  chk_irq_or: assert property (ce && sign_evt && en_next[0]
    |=> irq) else $error("enabled flag gave no interrupt");
endmodule

`default_nettype wire

// File: tb/aptd_core_test.sv
`timescale 1ns/100ps
`default_nettype none

module aptd_core_test;
  logic                   mclk, reset, smp_valid, smp_ready;
  logic                   sfr_wr, sfr_rd, vrms_upd, power_valid, irq;
  logic [7:0]             sfr_addr, sfr_wdata, sfr_rdata, rd_val;
  logic [23:0]            vrms_raw, vrms_out;
  aptd_pkg::aptd_sample_s smp;
  aptd_pkg::aptd_power_s  power;
  int                     failures, comparisons;

  aptd_core DUT (.mclk(mclk), .reset(reset), .ce(1'b1),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .smp_valid(smp_valid), .smp_ready(smp_ready), .smp(smp),
    .vrms_raw(vrms_raw), .zx_pulse(1'b0), .vrms_out(vrms_out),
    .vrms_upd(vrms_upd), .power(power), .power_valid(power_valid),
    .irq(irq));
  aptd_cpu_model cpu (.mclk(mclk), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata));

  // compare and report
  task automatic check(string what, logic [31:0] e, logic [31:0] got);
    comparisons++;
    if (got !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic rd_chk(string what, logic [7:0] a, logic [7:0] e);
    cpu.read(a, rd_val);
    check(what, {24'h0, e}, {24'h0, rd_val});
  endtask
  task automatic complete_run;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // bounded waits on design pulses
  task automatic wait_on(int which, int lim);
    for (int n = 0; n < lim; n++) begin
      @(negedge mclk);
      if (which == 0 && power_valid === 1'b1) return;
      if (which == 1 && vrms_upd === 1'b1) return;
      if (which == 2 && irq === 1'b1) return;
    end
    failures++;
    complete_run;
  endtask
  task automatic wait_pv(int k);
    repeat (k) wait_on(0, 20);
  endtask

  task automatic t_regs;
    rd_chk("nl cfg", 8'h0E, 8'h00);
    rd_chk("acc cfg", 8'h0F, 8'h00);
    rd_chk("irq en", 8'hD9, 8'h00);
    rd_chk("irq st", 8'hDC, 8'h00);
    rd_chk("unmapped", 8'h20, 8'h00);
    cpu.write(8'h13, 8'hFF);
    rd_chk("gain hi", 8'h13, 8'h0F);
    cpu.write(8'h13, 8'h00);
  endtask

  task automatic t_vrms;
    int n;
    cpu.write(8'h10, 8'h01);
    repeat (2) wait_on(1, 12);
    check("vrms plus", 32'h001040, {8'h0, vrms_out});
    cpu.write(8'h10, 8'h00);
    cpu.write(8'h11, 8'h08);
    repeat (2) wait_on(1, 12);
    check("vrms min", 32'hFE1000, {8'h0, vrms_out});
    cpu.write(8'h11, 8'h00);
    n = 0;
    repeat (50) begin
      @(negedge mclk);
      if (vrms_upd === 1'b1) n++;
    end
    check("vrms rate", 32'd10, n);
  endtask

  task automatic t_fifo;
    int n;
    smp = '{cur: 16'sh0010, volt: 16'sh0010};
    smp_valid = 1'b1;
    for (n = 0; n < 40 && smp_ready !== 1'b0; n++) @(negedge mclk);
    check("fifo full", 32'h0, {31'h0, smp_ready});
    wait_pv(1);
    smp_valid = 1'b0;
    n = 0;
    repeat (60) begin
      @(negedge mclk);
      if (power_valid === 1'b1) n++;
    end
    check("fifo drain", 32'd8, n);
    smp_valid = 1'b1;
  endtask

  task automatic t_power;
    logic [11:0] g[3] = '{12'h7FF, 12'h800, 12'h000};
    int          e[3] = '{383, 128, 256};
    wait_pv(3600);
    check("power", 32'd256, power.active);
    check("accum", 32'h1, {31'h0, power.accum !== 32'h0});
    rd_chk("no sign", 8'hDC, 8'h00);
    for (int i = 0; i < 3; i++) begin
      cpu.write(8'h12, g[i][7:0]);
      cpu.write(8'h13, {4'h0, g[i][11:8]});
      wait_pv(3);
      check("gain", e[i], power.active);
    end
    cpu.write(8'h15, 8'h01);
    wait_pv(3);
    check("offset up", 32'd257, power.active);
    cpu.write(8'h15, 8'hFF);
    wait_pv(3);
    check("offset down", 32'd255, power.active);
    cpu.write(8'h15, 8'h00);
  endtask

  task automatic t_noload;
    for (int m = 1; m < 4; m++) begin
      cpu.write(8'h0E, 8'(m));
      wait_pv(3);
      check("accum nl", 32'h0, power.accum);
      rd_chk("nl flag", 8'hDC, 8'h02);
    end
    cpu.write(8'hD9, 8'h02);
    check("irq nl", 32'h1, {31'h0, irq});
    cpu.write(8'hD9, 8'h00);
    check("irq masked", 32'h0, {31'h0, irq});
    cpu.write(8'h0E, 8'h00);
    cpu.write(8'hDC, 8'h00);
    wait_pv(3);
    rd_chk("nl off", 8'hDC, 8'h00);
  endtask

  task automatic t_sign;
    cpu.write(8'hD9, 8'h01);
    smp.cur = 16'shFFF0;
    wait_on(2, 3000);
    check("went neg", 32'h1, {31'h0, power.active[31]});
    wait_pv(3);
    check("irq held", 32'h1, {31'h0, irq});
    cpu.write(8'hDC, 8'h00);
    check("irq clr", 32'h0, {31'h0, irq});
    cpu.write(8'h0F, 8'h40);
    smp.cur = 16'sh0010;
    wait_on(2, 3000);
    check("went pos", 32'h0, {31'h0, power.active[31]});
  endtask

  // free running clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // main sequence
  initial begin
    failures = 0;
    comparisons = 0;
    reset = 1'b1;
    smp_valid = 1'b0;
    smp = '0;
    vrms_raw = 24'h001000;
    repeat (16) @(negedge mclk);
    reset = 1'b0;
    t_regs;
    t_vrms;
    t_fifo;
    t_power;
    t_noload;
    t_sign;
    complete_run;
  end
endmodule

`default_nettype wire

// File: tb/aptd_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none

module aptd_cpu_model (
  // clock
  input  wire logic       mclk,
  // register port
  output logic      [7:0] sfr_addr,
  output logic            sfr_wr,
  output logic            sfr_rd,
  output logic      [7:0] sfr_wdata,
  input  wire logic [7:0] sfr_rdata
);
  // idle port at time zero
  initial begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
  end

  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge mclk);
    sfr_wr = 1'b0;
    sfr_wdata = ~d; // released data shows inverse
  endtask

  // one read, data taken a cycle later
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge mclk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask
endmodule

`default_nettype wire
